// ==== common/io_channel_pkg.sv ====
// Purpose: shared constants and types for the eight-bit expansion slot bus
// Assumes: one core clock of 125 MHz feeds both ends
// Notes:   cycle counts are derived from the nanosecond figures below
package io_channel_pkg;

    // ------------------------------------------------------------
    // widths and clock figures
    // ------------------------------------------------------------
    localparam int ADDR_W = 20;
    localparam int DATA_W = 8;
    localparam int CORE_PERIOD_NS = 8;
    localparam longint unsigned CORE_CLK_HZ = 64'd125000000;
    localparam longint unsigned REF_CLK_HZ = 64'd14318180;
    // phase step of a 32-bit accumulator; its top bit is the 50% reference clock
    localparam logic [31:0] REF_CLK_STEP = 32'((REF_CLK_HZ << 32) / CORE_CLK_HZ);
    localparam int NORMAL_PERIOD_NS = 210;
    localparam int HIGH_PERIOD_NS = 100;
    localparam logic [4:0] NORMAL_PERIOD_CYC = 5'(NORMAL_PERIOD_NS / CORE_PERIOD_NS);
    localparam logic [4:0] HIGH_PERIOD_CYC = 5'(HIGH_PERIOD_NS / CORE_PERIOD_NS);
    // high phase is one third of the period
    localparam logic [4:0] NORMAL_HIGH_CYC = 5'(NORMAL_PERIOD_NS / (3 * CORE_PERIOD_NS));
    localparam logic [4:0] HIGH_HIGH_CYC = 5'(HIGH_PERIOD_NS / (3 * CORE_PERIOD_NS));

    // ------------------------------------------------------------
    // bus protocol values
    // ------------------------------------------------------------
    localparam logic [3:0] MAX_WAIT_CLOCKS = 4'hA;
    localparam logic [3:0] STROBES_IDLE = 4'hF;
    localparam logic [3:0] GRANTS_IDLE = 4'hF;
    localparam logic [1:0] REFRESH_CHANNEL = 2'h0;
    localparam logic [7:0] FLOAT_DATA = 8'hFF;
    localparam logic [ADDR_W-1:0] ROM_EXP_BASE = 20'hC0000;
    localparam logic [ADDR_W-1:0] ROM_EXP_LAST = 20'hEFFFF;

    // command kind doubles as the index of its strobe in the strobe vector
    typedef enum logic [1:0] {CMD_MRD, CMD_MWR, CMD_IRD, CMD_IWR} bus_cmd_t;

    function automatic logic in_rom_expansion(input logic [ADDR_W-1:0] a);
        return (a >= ROM_EXP_BASE) && (a <= ROM_EXP_LAST);
    endfunction

endpackage

// ==== common/io_channel_if.sv ====
// Purpose: slot bus wiring between the system board and one card
// Assumes: a single card on the bus
// Notes:   the shared data, ready and check lines are resolved here
`timescale 1ns/10ps
`default_nettype none
interface io_channel_if;
    logic reference_clock_out;
    logic bus_clock;
    logic bus_reset_out;
    logic [19:0] bus_address;
    logic ale;
    logic memory_read_strobe_n;
    logic memory_write_strobe_n;
    logic io_read_strobe_n;
    logic io_write_strobe_n;
    logic dma_owns_bus;
    logic terminal_count;
    logic [3:0] dma_grant_n;
    logic [3:1] dma_request_lines;
    logic [7:2] interrupt_request_lines;
    logic [7:0] board_data_out;
    logic board_data_oe;
    logic [7:0] card_data_out;
    logic card_data_oe;
    logic card_ready_out;
    logic card_ready_oe;
    logic card_check_out;
    logic card_check_oe;
    logic [7:0] bus_data;
    logic target_ready;
    logic channel_parity_fault_n;

    // ------------------------------------------------------------
    // wire resolution: undriven lines float high
    // ------------------------------------------------------------
    assign bus_data = board_data_oe ? board_data_out :
                      (card_data_oe ? card_data_out : io_channel_pkg::FLOAT_DATA);
    assign target_ready = card_ready_oe ? card_ready_out : 1'b1;
    assign channel_parity_fault_n = card_check_oe ? card_check_out : 1'b1;

    modport board (
        output reference_clock_out, bus_clock, bus_reset_out, bus_address, ale,
        output memory_read_strobe_n, memory_write_strobe_n,
        output io_read_strobe_n, io_write_strobe_n,
        output dma_owns_bus, terminal_count, dma_grant_n,
        output board_data_out, board_data_oe,
        input dma_request_lines, interrupt_request_lines,
        input bus_data, target_ready, channel_parity_fault_n
    );
    modport card (
        input reference_clock_out, bus_clock, bus_reset_out, bus_address, ale,
        input memory_read_strobe_n, memory_write_strobe_n,
        input io_read_strobe_n, io_write_strobe_n,
        input dma_owns_bus, terminal_count, dma_grant_n, bus_data,
        output dma_request_lines, interrupt_request_lines,
        output card_data_out, card_data_oe, card_ready_out, card_ready_oe,
        output card_check_out, card_check_oe
    );
endinterface
`default_nettype wire

// ==== rtl/io_channel_board.sv ====
// Purpose: system board end of the eight-bit slot bus
// Assumes: cards answer on the same core clock; slot inputs other than data are synchronised anyway
// Notes:   one processor or one DMA transfer at a time; a pending processor cycle wins at idle
//
// Operation
// - free-running 14.31818 MHz reference, 50% duty
// - bus clock 210/100 ns period, 33% duty
// - bus reset high, changes on clock fall
// - 20-bit address from processor or DMA
// - address latch pulse each processor cycle
// - low channel check raises non-maskable interrupt
// - ready low inserts wait states
// - slow target pulls ready low on decode
// - target holds ready low ten clocks at most
// - interrupt requests 2 highest, 7 lowest
// - card holds interrupt request high until serviced
// - active-low I/O read and write strobes
// - active-low memory read and write strobes
// - DMA requests 1 highest, 3 lowest
// - card holds DMA request until acknowledged
// - active-low acknowledges, channel 0 for refresh
// - address enable high while DMA owns bus
// - terminal-count pulse at DMA terminal count
// - 192K region left for expansion read-only memory
`timescale 1ns/10ps
`default_nettype none
module io_channel_board (
    input wire logic core_clk,
    input wire logic rst_n,
    io_channel_if.board slot,
    input wire logic high_speed,
    input wire logic power_fail,
    input wire logic cpu_req,
    input wire logic cpu_write,
    input wire logic cpu_io,
    input wire logic [19:0] cpu_addr,
    input wire logic [7:0] cpu_wdata,
    output logic cpu_ready,
    output logic cpu_done,
    output logic [7:0] cpu_rdata,
    input wire logic refresh_req,
    input wire logic [19:0] dma_addr,
    input wire logic dma_to_memory,
    input wire logic dma_terminal,
    input wire logic [7:0] dma_wdata,
    output logic [1:0] dma_channel,
    output logic dma_done,
    output logic [7:0] dma_rdata,
    output logic nmi,
    output logic int_pending,
    output logic [2:0] int_level,
    output logic rom_expansion_access
);

    typedef enum {S_IDLE, S_T1, S_T2, S_T3, S_T4} bus_state_t;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [2:0] highest_irq(input logic [7:2] req);
        logic [2:0] lvl;
        lvl = 3'h7;
        for (int i = 7; i >= 2; i--) begin
            if (req[i]) begin
                lvl = 3'(i);
            end
        end
        return lvl;
    endfunction

    function automatic logic [1:0] pick_dma(input logic refresh, input logic [3:1] drq);
        logic [1:0] ch;
        ch = 2'h3;
        if (refresh) begin
            ch = io_channel_pkg::REFRESH_CHANNEL;
        end else if (drq[1]) begin
            ch = 2'h1;
        end else if (drq[2]) begin
            ch = 2'h2;
        end
        return ch;
    endfunction

    // ------------------------------------------------------------
    // input synchronisers: ready, check, irq[7:2], drq[3:1]
    // ------------------------------------------------------------
    logic [10:0] sync_1;
    logic [10:0] sync_2;
    wire [10:0] raw_in = {slot.target_ready, slot.channel_parity_fault_n,
                          slot.interrupt_request_lines, slot.dma_request_lines};
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync_1 <= 11'h600;
            sync_2 <= 11'h600;
        end else begin
            sync_1 <= raw_in;
            sync_2 <= sync_1;
        end
    end
    wire ready_s = sync_2[10];
    wire check_n_s = sync_2[9];
    wire [7:2] irq_s = sync_2[8:3];
    wire [3:1] drq_s = sync_2[2:0];

    // ------------------------------------------------------------
    // reference oscillator and bus clock
    // ------------------------------------------------------------
    logic [31:0] ref_acc;
    logic [4:0] clk_cnt;
    logic fast;
    wire [4:0] period_cyc = fast ? io_channel_pkg::HIGH_PERIOD_CYC
                                 : io_channel_pkg::NORMAL_PERIOD_CYC;
    wire [4:0] high_cyc = fast ? io_channel_pkg::HIGH_HIGH_CYC
                               : io_channel_pkg::NORMAL_HIGH_CYC;
    wire at_wrap = clk_cnt == period_cyc - 5'h1;
    wire [4:0] next_clk_cnt = at_wrap ? 5'h0 : clk_cnt + 5'h1;
    // fall marks the core edge on which the bus clock drops
    wire fall = clk_cnt == high_cyc - 5'h1;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ref_acc <= 32'h0;
            clk_cnt <= 5'h0;
            fast <= 1'b0;
            slot.bus_clock <= 1'b0;
        end else begin
            ref_acc <= ref_acc + io_channel_pkg::REF_CLK_STEP;
            clk_cnt <= next_clk_cnt;
            slot.bus_clock <= next_clk_cnt < high_cyc;
            if (at_wrap) begin
                fast <= high_speed; // speed changes only between periods
            end
        end
    end
    assign slot.reference_clock_out = ref_acc[31];

    // ------------------------------------------------------------
    // bus reset, check and interrupt status
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            slot.bus_reset_out <= 1'b1;
            nmi <= 1'b0;
            int_pending <= 1'b0;
            int_level <= 3'h7;
        end else begin
            if (fall) begin
                slot.bus_reset_out <= power_fail;
            end
            nmi <= !check_n_s;
            int_pending <= |irq_s;
            int_level <= highest_irq(irq_s);
        end
    end

    // ------------------------------------------------------------
    // cycle sequencer
    // ------------------------------------------------------------
    bus_state_t state;
    logic cpu_pend;
    logic is_dma;
    logic rd_cycle;
    logic last_xfer;
    logic [1:0] cmd;
    logic [7:0] wdata;
    logic [3:0] strobes_n;
    wire dma_want = refresh_req || (|drq_s);
    wire [1:0] dma_pick = pick_dma(refresh_req, drq_s);
    // a DMA transfer uses one memory strobe; the card decodes its acknowledge
    wire [1:0] dma_cmd = (dma_to_memory && !refresh_req) ? 2'(io_channel_pkg::CMD_MWR)
                                                          : 2'(io_channel_pkg::CMD_MRD);
    wire [1:0] cpu_cmd = {cpu_io, cpu_write};
    wire start = fall && state == S_IDLE && !slot.bus_reset_out;

    assign cpu_ready = !cpu_pend && !slot.bus_reset_out && !slot.dma_owns_bus && !dma_want;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= S_IDLE;
            cpu_pend <= 1'b0;
            is_dma <= 1'b0;
            rd_cycle <= 1'b0;
            last_xfer <= 1'b0;
            cmd <= 2'h0;
            wdata <= 8'h0;
            strobes_n <= io_channel_pkg::STROBES_IDLE;
            slot.bus_address <= 20'h0;
            slot.ale <= 1'b0;
            slot.dma_owns_bus <= 1'b0;
            slot.dma_grant_n <= io_channel_pkg::GRANTS_IDLE;
            slot.terminal_count <= 1'b0;
            slot.board_data_oe <= 1'b0;
            dma_channel <= 2'h0;
            dma_done <= 1'b0;
            dma_rdata <= 8'h0;
            cpu_done <= 1'b0;
            cpu_rdata <= 8'h0;
            rom_expansion_access <= 1'b0;
        end else begin
            cpu_done <= 1'b0;
            dma_done <= 1'b0;
            if (cpu_req && cpu_ready) begin
                cpu_pend <= 1'b1;
                cmd <= cpu_cmd;
                slot.bus_address <= cpu_addr;
                wdata <= cpu_wdata;
            end
            if (fall) begin
                case (state)
                    S_IDLE: begin
                        if (start && dma_want && !cpu_pend) begin
                            state <= S_T1;
                            is_dma <= 1'b1;
                            dma_channel <= dma_pick;
                            cmd <= dma_cmd;
                            slot.bus_address <= dma_addr;
                            wdata <= dma_wdata;
                            last_xfer <= dma_terminal && !refresh_req;
                            slot.dma_owns_bus <= 1'b1;
                            slot.dma_grant_n[dma_pick] <= 1'b0;
                        end else if (start && cpu_pend) begin
                            state <= S_T1;
                            is_dma <= 1'b0;
                            slot.ale <= 1'b1;
                        end
                    end
                    S_T1: begin
                        state <= S_T2;
                        slot.ale <= 1'b0;
                        rd_cycle <= !cmd[0];
                        strobes_n[cmd] <= 1'b0;
                        rom_expansion_access <= !cmd[1]
                                                && io_channel_pkg::in_rom_expansion(
                                                       slot.bus_address);
                        slot.board_data_oe <= is_dma ? (cmd == 2'(io_channel_pkg::CMD_MRD))
                                                     : cmd[0];
                    end
                    S_T2: begin
                        state <= S_T3;
                    end
                    S_T3: begin
                        if (ready_s) begin
                            state <= S_T4;
                            strobes_n <= io_channel_pkg::STROBES_IDLE;
                            slot.terminal_count <= is_dma && last_xfer;
                            if (is_dma) begin
                                dma_rdata <= slot.bus_data;
                            end else if (rd_cycle) begin
                                cpu_rdata <= slot.bus_data;
                            end
                        end
                    end
                    S_T4: begin
                        state <= S_IDLE;
                        slot.board_data_oe <= 1'b0;
                        slot.terminal_count <= 1'b0;
                        slot.dma_owns_bus <= 1'b0;
                        slot.dma_grant_n <= io_channel_pkg::GRANTS_IDLE;
                        rom_expansion_access <= 1'b0;
                        cpu_done <= !is_dma;
                        dma_done <= is_dma;
                        if (!is_dma) begin
                            cpu_pend <= 1'b0;
                        end
                    end
                    default: begin
                        state <= S_IDLE;
                    end
                endcase
            end
        end
    end

    assign slot.board_data_out = wdata;
    assign slot.memory_read_strobe_n = strobes_n[io_channel_pkg::CMD_MRD];
    assign slot.memory_write_strobe_n = strobes_n[io_channel_pkg::CMD_MWR];
    assign slot.io_read_strobe_n = strobes_n[io_channel_pkg::CMD_IRD];
    assign slot.io_write_strobe_n = strobes_n[io_channel_pkg::CMD_IWR];

endmodule // io_channel_board
`default_nettype wire

// ==== rtl/io_channel_card.sv ====
// Purpose: expansion card end of the eight-bit slot bus
// Assumes: one I/O holding register, one DMA channel, one interrupt line
// Notes:   bus inputs pass two flops; address and data are read only under a settled strobe
`timescale 1ns/10ps
`default_nettype none
module io_channel_card #(
    parameter logic [15:0] IO_BASE = 16'h0300,
    parameter int DMA_LINE = 1,
    parameter int IRQ_LINE = 5,
    parameter logic [3:0] WAIT_STATES = 4'h2
) (
    input wire logic core_clk,
    input wire logic rst_n,
    io_channel_if.card slot,
    input wire logic irq_raise,
    input wire logic irq_clear,
    input wire logic dma_start,
    input wire logic [7:0] dma_tx_byte,
    input wire logic parity_fault,
    output logic [7:0] holding_reg,
    output logic [7:0] dma_rx_byte,
    output logic io_written,
    output logic dma_done,
    output logic card_reset
);

    // ------------------------------------------------------------
    // synchronisers: reset, clock, enable, strobes, grants
    // ------------------------------------------------------------
    localparam logic [10:0] SYNC_IDLE = 11'h4FF;
    // wait states beyond the bus limit would hang the board
    localparam logic [3:0] WAIT_EFF = (WAIT_STATES > io_channel_pkg::MAX_WAIT_CLOCKS)
                                      ? io_channel_pkg::MAX_WAIT_CLOCKS : WAIT_STATES;
    logic [10:0] sync_1;
    logic [10:0] sync_2;
    logic clk_d;
    wire [3:0] strobes_in = {slot.io_write_strobe_n, slot.io_read_strobe_n,
                             slot.memory_write_strobe_n, slot.memory_read_strobe_n};
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync_1 <= SYNC_IDLE;
            sync_2 <= SYNC_IDLE;
            clk_d <= 1'b0;
        end else begin
            sync_1 <= {slot.bus_reset_out, slot.bus_clock, slot.dma_owns_bus,
                       strobes_in, slot.dma_grant_n};
            sync_2 <= sync_1;
            clk_d <= sync_2[9];
        end
    end
    wire reset_s = sync_2[10];
    wire clk_fall = clk_d && !sync_2[9];
    wire own_s = sync_2[8];
    wire [3:0] stb_n = sync_2[7:4];
    wire my_grant = !sync_2[DMA_LINE];

    // ------------------------------------------------------------
    // decode and wait states
    // ------------------------------------------------------------
    logic [3:0] wait_cnt;
    logic hit_d;
    logic grant_d;
    wire addr_hit = slot.bus_address[15:0] == IO_BASE;
    wire io_rd = !stb_n[io_channel_pkg::CMD_IRD];
    wire io_wr = !stb_n[io_channel_pkg::CMD_IWR];
    wire io_hit = (io_rd || io_wr) && !own_s && addr_hit;
    wire dma_rd = my_grant && !stb_n[io_channel_pkg::CMD_MRD];
    wire dma_wr = my_grant && !stb_n[io_channel_pkg::CMD_MWR];

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wait_cnt <= 4'h0;
            hit_d <= 1'b0;
            grant_d <= 1'b0;
            holding_reg <= 8'h0;
            dma_rx_byte <= 8'h0;
            io_written <= 1'b0;
            dma_done <= 1'b0;
        end else begin
            hit_d <= io_hit && io_wr;
            grant_d <= my_grant;
            io_written <= hit_d && !(io_hit && io_wr);
            dma_done <= grant_d && !my_grant;
            if (!io_hit) begin
                wait_cnt <= 4'h0;
            end else if (clk_fall && wait_cnt < WAIT_EFF) begin
                wait_cnt <= wait_cnt + 4'h1;
            end
            if (io_hit && io_wr) begin
                holding_reg <= slot.bus_data;
            end
            if (dma_rd) begin
                dma_rx_byte <= slot.bus_data;
            end
        end
    end

    // pull ready low from decode until the wait count runs out
    assign slot.card_ready_out = 1'b0;
    assign slot.card_ready_oe = io_hit && wait_cnt < WAIT_EFF;
    assign slot.card_data_out = dma_wr ? dma_tx_byte : holding_reg;
    assign slot.card_data_oe = (io_hit && io_rd) || dma_wr;
    assign slot.card_check_out = 1'b0;
    assign slot.card_check_oe = parity_fault;

    // ------------------------------------------------------------
    // interrupt and DMA requests
    // ------------------------------------------------------------
    logic irq_level;
    logic dma_pend;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_level <= 1'b0;
            dma_pend <= 1'b0;
            card_reset <= 1'b1;
        end else begin
            card_reset <= reset_s;
            if (reset_s) begin
                irq_level <= 1'b0;
                dma_pend <= 1'b0;
            end else begin
                irq_level <= irq_raise || (irq_level && !irq_clear);
                dma_pend <= dma_start || (dma_pend && !my_grant);
            end
        end
    end

    always_comb begin
        slot.interrupt_request_lines = 6'h00;
        slot.interrupt_request_lines[IRQ_LINE] = irq_level;
        slot.dma_request_lines = 3'h0;
        slot.dma_request_lines[DMA_LINE] = dma_pend;
    end

endmodule // io_channel_card
`default_nettype wire

// ==== verif/io_channel_checker.sv ====
// Purpose: slot bus protocol checks
// Assumes: one core clock for both ends
// Notes:   ready bound in core cycles, 26 per slow bus clock
`timescale 1ns/10ps
`default_nettype none
module io_channel_checker (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic reference_clock_out,
    input wire logic bus_clock,
    input wire logic bus_reset_out,
    input wire logic ale,
    input wire logic memory_read_strobe_n,
    input wire logic memory_write_strobe_n,
    input wire logic io_read_strobe_n,
    input wire logic io_write_strobe_n,
    input wire logic dma_owns_bus,
    input wire logic terminal_count,
    input wire logic [3:0] dma_grant_n,
    input wire logic [3:1] dma_request_lines,
    input wire logic target_ready
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    wire logic [3:0] cmd_n = {memory_read_strobe_n, memory_write_strobe_n,
        io_read_strobe_n, io_write_strobe_n};
    logic [8:0] low_run;
    sequence bclk_high_s; bus_clock [*4]; endsequence
    sequence bclk_low_s; !bus_clock [*8]; endsequence
    sequence ready_held_s; !target_ready [*3]; endsequence
    // ----------------------------------------
    // run of ready low, counted in core cycles
    // ----------------------------------------
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            low_run <= 9'h000;
        end else begin
            low_run <= target_ready ? 9'h000 : low_run + 9'h001;
        end
    end
    a_ref_duty: assert property (
        $rose(reference_clock_out) |-> reference_clock_out [*4] ##[1:2] !reference_clock_out)
        else $error("reference clock duty off");
    a_bclk_high: assert property ($rose(bus_clock) |-> bclk_high_s)
        else $error("bus clock high phase short");
    a_bclk_low: assert property ($fell(bus_clock) |-> bclk_low_s)
        else $error("bus clock low phase short");
    a_reset_on_low: assert property ($changed(bus_reset_out) |-> !bus_clock)
        else $error("bus reset moved off the clock fall");
    a_ale_idle: assert property (ale |-> &cmd_n && !dma_owns_bus)
        else $error("address latch with strobe or dma");
    a_wait_holds: assert property (ready_held_s ##0 !(&cmd_n) |=> !(&cmd_n))
        else $error("strobe ended while not ready");
    a_ready_bound: assert property (low_run <= 9'd260)
        else $error("ready held low too long");
    a_one_strobe: assert property ($countones(~cmd_n) <= 1)
        else $error("two command strobes low");
    a_grant_owns: assert property (
        !(&dma_grant_n) |-> dma_owns_bus && $onehot(~dma_grant_n))
        else $error("grant without bus ownership");
    a_tc_in_dma: assert property (terminal_count |-> dma_owns_bus)
        else $error("terminal count outside dma");
    a_drq_till_grant: assert property ($fell(|dma_request_lines) |-> dma_owns_bus)
        else $error("dma request dropped before grant");
endmodule // io_channel_checker
`default_nettype wire

// ==== verif/eight_bit_io_channel_bus_test.sv ====
// Purpose: board and card joined, compared with a bench model
// Assumes: card at its default base, dma line 1, interrupt line 5
// Notes:   written bytes are queued; first cycle runs at normal speed
`timescale 1ns/10ps
`default_nettype none
module eight_bit_io_channel_bus_test;
    logic core_clk = 0, rst_n = 0, hs = 0, pf = 0, req = 0, wr = 0, io = 0, rf = 0;
    logic tm = 0, irs = 0, icl = 0, ds = 0, pfl = 0;
    logic [19:0] a = 0, da = 0;
    logic [7:0] wd = 0;
    wire logic rdy, done, ddone, nmi, ip, rom, cdone, crst, iw;
    wire logic [7:0] rd, drd, hreg, rxb;
    wire logic [2:0] lvl;
    wire logic [1:0] ch;
    int fails = 0, compares = 0, seed = 32'h2961d0db, k, j, bd = 0, cd = 0, tc = 0, rc = 0, wc = 0;
    logic [7:0] q[$];
    io_channel_if slot_bus ();
    io_channel_board io_channel_board_inst (.core_clk(core_clk), .rst_n(rst_n),
        .slot(slot_bus), .high_speed(hs), .power_fail(pf), .cpu_req(req), .cpu_write(wr),
        .cpu_io(io), .cpu_addr(a), .cpu_wdata(wd), .cpu_ready(rdy), .cpu_done(done),
        .cpu_rdata(rd), .refresh_req(rf), .dma_addr(da), .dma_to_memory(tm),
        .dma_terminal(tm), .dma_wdata(wd), .dma_channel(ch), .dma_done(ddone),
        .dma_rdata(drd), .nmi(nmi), .int_pending(ip), .int_level(lvl),
        .rom_expansion_access(rom));
    io_channel_card io_channel_card_inst (.core_clk(core_clk), .rst_n(rst_n),
        .slot(slot_bus), .irq_raise(irs), .irq_clear(icl), .dma_start(ds), .dma_tx_byte(wd),
        .parity_fault(pfl), .holding_reg(hreg), .dma_rx_byte(rxb), .io_written(iw),
        .dma_done(cdone), .card_reset(crst));
    io_channel_checker io_channel_checker_inst (.core_clk(core_clk), .rst_n(rst_n),
        .reference_clock_out(slot_bus.reference_clock_out), .bus_clock(slot_bus.bus_clock),
        .bus_reset_out(slot_bus.bus_reset_out), .ale(slot_bus.ale),
        .memory_read_strobe_n(slot_bus.memory_read_strobe_n),
        .memory_write_strobe_n(slot_bus.memory_write_strobe_n),
        .io_read_strobe_n(slot_bus.io_read_strobe_n),
        .io_write_strobe_n(slot_bus.io_write_strobe_n), .dma_owns_bus(slot_bus.dma_owns_bus),
        .terminal_count(slot_bus.terminal_count), .dma_grant_n(slot_bus.dma_grant_n),
        .dma_request_lines(slot_bus.dma_request_lines), .target_ready(slot_bus.target_ready));
    always #4 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        bd += ddone;
        cd += cdone;
        tc += slot_bus.terminal_count;
        rc += rom;
        wc += iw;
    end
    task chk(input logic [19:0] s, input logic [19:0] e);
        compares++;
        if (s !== e) begin
            fails++;
            $display("unexpected at %0t: %0h vs %0h", $time, s, e);
        end
    endtask
    task tick;
        @(posedge core_clk);
        #1;
    endtask
    task cyc(input logic [1:0] c, input logic [19:0] ad);
        while (rdy !== 1'b1) tick;
        {io, wr} = c;
        a = ad;
        wd = 8'($random(seed));
        req = 1;
        tick;
        req = 0;
        while (done !== 1'b1) tick;
    endtask
    task end_sim;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (12) @(posedge core_clk);
        #1 rst_n = 1;
        cyc(2'h3, 20'h00300);
        q.push_back(wd);
        chk(hreg, q[0]);
        hs = 1;
        cyc(2'h2, 20'h00300);
        chk(rd, q.pop_front());
        cyc(2'h1, 20'hC8000);
        chk(rc != 0, 1'b1);
        k = rc;
        cyc(2'h0, 20'h10000);
        chk(rd, 8'hFF);
        chk(20'(rc), 20'(k));
        chk(20'(wc), 20'h1);
        for (int d = 0; d < 2; d++) begin
            tm = d[0];
            da = 20'h02000 + 20'(d);
            wd = 8'($random(seed));
            k = bd;
            j = cd;
            ds = 1;
            tick;
            ds = 0;
            while (bd == k || cd == j) tick;
            chk(tm ? drd : rxb, wd);
            chk(ch, 2'h1);
            chk(tc != 0, tm);
        end
        k = bd;
        rf = 1;
        while (bd == k) tick;
        rf = 0;
        chk(ch, 2'h0);
        irs = 1;
        tick;
        irs = 0;
        while (ip !== 1'b1) tick;
        chk(lvl, 3'h5);
        icl = 1;
        tick;
        icl = 0;
        while (ip !== 1'b0) tick;
        chk(lvl, 3'h7);
        pfl = 1;
        repeat (4) tick;
        chk(nmi, 1'b1);
        pfl = 0;
        pf = 1;
        while (crst !== 1'b1) tick;
        chk({crst, rdy}, 2'h2);
        end_sim;
    end
    // a hang costs one mismatch and ends the run
    initial begin
        #400000;
        fails++;
        end_sim;
    end
endmodule // eight_bit_io_channel_bus_test
`default_nettype wire
